// ===== inc/swm_params.svh
// swm_params.svh: offsets, field positions, reset values
// assumes: included by bare name from package and modules
`ifndef SWM_PARAMS_SVH
`define SWM_PARAMS_SVH

`define SWM_NSRC      4
`define SWM_AW        4
`define SWM_OFS_CTRL  4'h0
`define SWM_OFS_CLR   4'h4
`define SWM_LANE_W    8
`define SWM_SEL_LSB   4
`define SWM_REC_LSB   2
`define SWM_EN_BIT    0
`define SWM_SEL_RST   3'h2
`define SWM_REC_RST   2'h0
`define SWM_WORD_ZERO 32'h0000_0000

`endif

// ===== inc/swm_pkg.sv
// swm_pkg.sv: types of the standby wake mode control block
// assumes: swm_params.svh on the include path
`include "swm_params.svh"

package swm_pkg;

   // wake condition select encoding
   typedef enum logic [2:0] {
      SWM_SEL_LOW  = 3'h0,
      SWM_SEL_HIGH = 3'h1,
      SWM_SEL_FALL = 3'h2,
      SWM_SEL_RISE = 3'h3,
      SWM_SEL_BOTH = 3'h4
   } swm_sel_t;

   // one byte lane of the control word
   typedef struct packed {
      logic       rsv;
      logic [2:0] sel;
      logic [1:0] rec;
      logic       undef;
      logic       en;
   } swm_lane_t;

   // per-source detector result
   typedef struct packed {
      logic       req;
      logic [1:0] rec;
   } swm_det_t;

endpackage : swm_pkg

// ===== logic/swm_rst_sync.sv
// swm_rst_sync.sv: two-flop release of the async reset
// assumes: RESET_N asynchronous, active low
`timescale 1ns/1ps
`default_nettype none

module swm_rst_sync (
   // clock and raw reset
   input  wire logic clk,
   input  wire logic rst_in_n,
   // released copy
   output var  logic rst_out_n
);
   logic meta_r;

   always_ff @(posedge clk or negedge rst_in_n) begin
      if (!rst_in_n) begin
         meta_r    <= 1'b0;
         rst_out_n <= 1'b0;
      end else begin
         meta_r    <= 1'b1;
         rst_out_n <= meta_r;
      end
   end
endmodule : swm_rst_sync

`default_nettype wire

// ===== logic/swm_wake_det.sv
// swm_wake_det.sv: one wake source detector with edge record
// assumes: line synchronous to clk, clr a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "swm_params.svh"

module swm_wake_det (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // source and configuration
   input  wire logic             line,
   input  wire swm_pkg::swm_sel_t sel,
   input  wire logic             en,
   input  wire logic             clr,
   // result
   output var  swm_pkg::swm_det_t det
);
   import swm_pkg::*;

   logic       prev_r, prev_nxt;
   logic       seen_r, seen_nxt;
   logic       pend_r, pend_nxt;
   logic [1:0] rec_r,  rec_nxt;
   logic       req_r,  req_nxt;
   logic       rise, fall, hit, level;

   always_comb begin
      rise     = seen_r & ~prev_r & line;
      fall     = seen_r & prev_r & ~line;
      level    = 1'b0;
      case (sel)
         SWM_SEL_LOW: begin
            hit   = ~line;
            level = 1'b1;
         end
         SWM_SEL_HIGH: begin
            hit   = line;
            level = 1'b1;
         end
         SWM_SEL_FALL: hit = fall;
         SWM_SEL_RISE: hit = rise;
         SWM_SEL_BOTH: hit = rise | fall;
         default:      hit = 1'b0;
      endcase
      prev_nxt = line;
      seen_nxt = 1'b1;
      // sticky edge request, a set beats the clear
      pend_nxt = (pend_r & ~clr) | (hit & en & ~level);
      rec_nxt  = clr ? `SWM_REC_RST : rec_r;
      if (en && sel == SWM_SEL_BOTH) begin
         rec_nxt = rec_nxt | {fall, rise};
      end
      req_nxt  = en & (level ? hit : pend_nxt);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         seen_r <= 1'b0;
         pend_r <= 1'b0;
         rec_r  <= `SWM_REC_RST;
         req_r  <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
         seen_r <= seen_nxt;
         pend_r <= pend_nxt;
         rec_r  <= rec_nxt;
         req_r  <= req_nxt;
      end
   end

   assign det = '{req: req_r, rec: rec_r};
endmodule : swm_wake_det

`default_nettype wire

// ===== logic/swm_wake_ctrl.sv
// swm_wake_ctrl.sv: standby wake mode control for four sources
// assumes: plain register port, strobes one cycle, inputs
// synchronous to MCLK, software keeps the select then enable order
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "swm_params.svh"

////////////////////////////////////////////////////////////////
module swm_wake_ctrl #(
   parameter int NSRC = `SWM_NSRC,
   parameter int AW   = `SWM_AW
) (
   // clock and reset
   input  wire logic            MCLK,
   input  wire logic            RESET_N,
   // register port
   input  wire logic [AW-1:0]   ADDR,
   input  wire logic [31:0]     WDATA,
   input  wire logic            WR,
   input  wire logic            RD,
   output var  logic [31:0]     RDATA,
   // external wake lines
   input  wire logic            EXT_WAKE_LINE_8,
   input  wire logic            EXT_WAKE_LINE_9,
   input  wire logic            EXT_WAKE_LINE_A,
   input  wire logic            EXT_WAKE_LINE_B,
   // standby release side
   output var  logic [NSRC-1:0] WAKE_REQ,
   output var  logic            WAKE_ANY
);
   import swm_pkg::*;

   ////////////////////////////////////////////////////////////////
   // helpers

   function automatic swm_lane_t lane_of(
      input logic [31:0] word,
      input int          idx
   );
      lane_of = swm_lane_t'(word[idx*`SWM_LANE_W +: `SWM_LANE_W]);
   endfunction : lane_of

   function automatic logic [31:0] ctrl_word(
      input swm_sel_t [NSRC-1:0] s,
      input logic     [NSRC-1:0] e,
      input swm_det_t [NSRC-1:0] d
   );
      swm_lane_t ln;
      ctrl_word = `SWM_WORD_ZERO;
      for (int k = 0; k < NSRC; k++) begin
         ln.rsv   = 1'b0;
         ln.sel   = s[k];
         ln.rec   = d[k].rec;
         ln.undef = 1'b0;
         ln.en    = e[k];
         ctrl_word[k*`SWM_LANE_W +: `SWM_LANE_W] = ln;
      end
   endfunction : ctrl_word

   ////////////////////////////////////////////////////////////////
   // reset release

   logic rst_n;

   swm_rst_sync u_rst (
      .clk       (MCLK),
      .rst_in_n  (RESET_N),
      .rst_out_n (rst_n)
   );

   ////////////////////////////////////////////////////////////////
   // register decode

   logic            wr_ctrl, wr_clr, rd_ctrl;
   logic [NSRC-1:0] clr_pulse;

   always_comb begin
      wr_ctrl   = WR && ADDR == `SWM_OFS_CTRL;
      wr_clr    = WR && ADDR == `SWM_OFS_CLR;
      rd_ctrl   = RD && ADDR == `SWM_OFS_CTRL;
      clr_pulse = wr_clr ? WDATA[NSRC-1:0] : '0;
   end

   ////////////////////////////////////////////////////////////////
   // control fields

   swm_sel_t [NSRC-1:0] sel_r, sel_nxt;
   logic     [NSRC-1:0] en_r,  en_nxt;

   always_comb begin
      swm_lane_t ln;
      ln      = '0;
      sel_nxt = sel_r;
      en_nxt  = en_r;
      if (wr_ctrl) begin
         for (int k = 0; k < NSRC; k++) begin
            // record, reserved and undefined bits are dropped
            ln         = lane_of(WDATA, k);
            sel_nxt[k] = swm_sel_t'(ln.sel);
            en_nxt[k]  = ln.en;
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < NSRC; k++) begin
            sel_r[k] <= swm_sel_t'(`SWM_SEL_RST);
         end
         en_r <= '0;
      end else begin
         sel_r <= sel_nxt;
         en_r  <= en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // detectors

   logic     [NSRC-1:0] line_w;
   swm_det_t [NSRC-1:0] det_w;

   assign line_w = {EXT_WAKE_LINE_B, EXT_WAKE_LINE_A,
                    EXT_WAKE_LINE_9, EXT_WAKE_LINE_8};

   for (genvar g = 0; g < NSRC; g++) begin : g_det
      swm_wake_det u_det (
         .clk   (MCLK),
         .rst_n (rst_n),
         .line  (line_w[g]),
         .sel   (sel_r[g]),
         .en    (en_r[g]),
         .clr   (clr_pulse[g]),
         .det   (det_w[g])
      );
      assign WAKE_REQ[g] = det_w[g].req;
   end

   ////////////////////////////////////////////////////////////////
   // release summary and read data

   logic        any_nxt;
   logic [31:0] rdata_nxt;

   always_comb begin
      any_nxt   = 1'b0;
      for (int k = 0; k < NSRC; k++) begin
         any_nxt = any_nxt | det_w[k].req;
      end
      // data only in the cycle after the read, else zero
      rdata_nxt = rd_ctrl ? ctrl_word(sel_r, en_r, det_w)
                          : `SWM_WORD_ZERO;
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         WAKE_ANY <= 1'b0;
         RDATA    <= `SWM_WORD_ZERO;
      end else begin
         WAKE_ANY <= any_nxt;
         RDATA    <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks

   logic [NSRC-1:0] line_d_r;
   logic            seen_d_r;

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         line_d_r <= '0;
         seen_d_r <= 1'b0;
      end else begin
         line_d_r <= line_w;
         seen_d_r <= 1'b1;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!rst_n);

   a_rsv_bits_zero: assert property (
      RD |=> (RDATA[31] | RDATA[23] | RDATA[15] | RDATA[7]) == 1'b0)
      else $error("reserved bit read as one");

   a_sel_readback: assert property (
      rd_ctrl |=> RDATA[6:4] == $past(sel_r[0])
                  && RDATA[30:28] == $past(sel_r[3]))
      else $error("select field misplaced on read");

   a_write_to_read: assert property (
      wr_ctrl ##1 rd_ctrl |=> RDATA[24] == $past(WDATA[24], 2)
                              && RDATA[0] == $past(WDATA[0], 2))
      else $error("enable bit not stored");

   a_any_follows: assert property (
      (|WAKE_REQ) |=> WAKE_ANY)
      else $error("summary missed a request");

   a_rdata_idle: assert property (
      !rd_ctrl |=> RDATA == `SWM_WORD_ZERO)
      else $error("read data outside read cycle");

   for (genvar g = 0; g < NSRC; g++) begin : g_chk
      a_gate_off: assert property (
         !en_r[g] |=> !WAKE_REQ[g])
         else $error("disabled source raised request");

      a_low_level: assert property (
         en_r[g] && sel_r[g] == SWM_SEL_LOW && !line_w[g]
         |=> WAKE_REQ[g])
         else $error("low level did not request");

      a_high_level: assert property (
         en_r[g] && sel_r[g] == SWM_SEL_HIGH && line_w[g]
         |=> WAKE_REQ[g])
         else $error("high level did not request");

      a_rise_edge: assert property (
         en_r[g] && sel_r[g] == SWM_SEL_RISE && seen_d_r
         && !line_d_r[g] && line_w[g] ##1 en_r[g] && !clr_pulse[g]
         && sel_r[g] == SWM_SEL_RISE
         |-> WAKE_REQ[g] [*2])
         else $error("rising edge request not held");

      a_both_rec: assert property (
         en_r[g] && sel_r[g] == SWM_SEL_BOTH && seen_d_r
         && line_d_r[g] && !line_w[g] |=> det_w[g].rec[1])
         else $error("falling edge not recorded");

      a_clr_rec: assert property (
         clr_pulse[g] && !(en_r[g] && sel_r[g] == SWM_SEL_BOTH
         && seen_d_r && line_d_r[g] != line_w[g])
         |=> det_w[g].rec == 2'h0)
         else $error("clear left record set");

      a_rec_wr_ign: assert property (
         wr_ctrl && !clr_pulse[g] && !(en_r[g] && sel_r[g] == SWM_SEL_BOTH
         && seen_d_r && line_d_r[g] != line_w[g])
         |=> $stable(det_w[g].rec))
         else $error("record changed by write");
   end
endmodule : swm_wake_ctrl

`default_nettype wire

// ===== verification/swm_wake_src.sv
// swm_wake_src.sv: model of the four external wake lines
// assumes: bench sets wanted levels; lines follow one MCLK edge later
`timescale 1ns/1ps
`default_nettype none

module swm_wake_src (
   // clock
   input  wire logic       clk,
   // wanted levels and driven lines
   input  wire logic [3:0] tgt,
   output var  logic [3:0] line
);
   // a synchronous source only moves just after an edge
   always_ff @(posedge clk) begin
      line <= tgt;
   end
endmodule : swm_wake_src

`default_nettype wire

// ===== verification/tb_swm_wake_ctrl.sv
// tb_swm_wake_ctrl.sv: self-checking bench of the wake mode control
// assumes: swm_pkg, swm_wake_ctrl and swm_wake_src compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_swm_wake_ctrl;
   logic        mclk;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic [3:0]  addr;
   logic [3:0]  tgt;
   logic [3:0]  line;
   logic [3:0]  wake_req;
   logic        wake_any;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] ctrl;
   int          n_errors;
   int          checks_done;

   swm_wake_ctrl DUT (.MCLK(mclk), .RESET_N(rst_n), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .EXT_WAKE_LINE_8(line[0]), .EXT_WAKE_LINE_9(line[1]),
      .EXT_WAKE_LINE_A(line[2]), .EXT_WAKE_LINE_B(line[3]),
      .WAKE_REQ(wake_req), .WAKE_ANY(wake_any));

   swm_wake_src u_src (.clk(mclk), .tgt(tgt), .line(line));

   always #50 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h",
                  $time, what, got, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : wait_cyc

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp,
                         input string what);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      @(negedge mclk);
      chk(rdata, exp, what);
   endtask : rd_reg

   function automatic logic [31:0] with_lane(input int k,
                                             input logic [7:0] lane);
      logic [31:0] w;
      w = ctrl;
      w[8*k +: 8] = lane;
      return w;
   endfunction : with_lane

   task automatic set_lane(input int k, input logic [7:0] lane);
      ctrl = with_lane(k, lane);
      wr_reg(4'h0, ctrl);
   endtask : set_lane

   ////////////////////////////////////////////////////////////////
   task automatic t_reset_word;
      rd_reg(4'h0, 32'h2020_2020, "reset word");
      rd_reg(4'h4, 32'h0000_0000, "clear reg read");
   endtask : t_reset_word

   // record and spare bits written as ones must read back zero
   task automatic t_ro_bits;
      ctrl = 32'h4040_4040;
      wr_reg(4'h0, 32'hcece_cece);
      rd_reg(4'h0, ctrl, "read-only bits");
      wr_reg(4'h8, 32'hffff_ffff);
      rd_reg(4'h8, 32'h0000_0000, "unmapped read");
      rd_reg(4'h0, ctrl, "unmapped write leak");
   endtask : t_ro_bits

   // write strobe followed at once by a read strobe
   task automatic t_b2b;
      @(posedge mclk);
      addr  <= 4'h0;
      wdata <= 32'h4140_4041;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
      rd    <= 1'b1;
      @(posedge mclk);
      rd    <= 1'b0;
      @(negedge mclk);
      chk(rdata, 32'h4140_4041, "write then read");
      wr_reg(4'h0, ctrl); // enable off, select kept
   endtask : t_b2b

   task automatic t_mode(input int k, input logic [2:0] code);
      logic       idle;
      logic [7:0] lane;
      idle = (code == 3'h0) || (code == 3'h2);
      lane = {1'b0, code, 4'h0};
      tgt[k] <= idle;
      set_lane(k, lane); // select before enable
      wr_reg(4'h4, 32'h1 << k);
      set_lane(k, lane | 8'h01);
      wait_cyc(4);
      chk(32'(wake_req), 32'h0, "idle line");
      tgt[k] <= ~idle;
      wait_cyc(5);
      chk(32'({wake_any, wake_req}), 32'h10 | (32'h1 << k), "wake");
      if (code == 3'h4) begin
         rd_reg(4'h0, with_lane(k, 8'h45), "rise record");
      end
      tgt[k] <= idle;
      wait_cyc(5);
      chk(32'(wake_req), (code < 3'h2) ? 32'h0 : 32'h1 << k,
          "back idle");
      if (code == 3'h4) begin
         rd_reg(4'h0, with_lane(k, 8'h4d), "both record");
      end
      wr_reg(4'h4, 32'h1 << k);
      wait_cyc(3);
      chk(32'({wake_any, wake_req}), 32'h0, "after clear");
      if (code == 3'h4) begin
         rd_reg(4'h0, with_lane(k, 8'h41), "record cleared");
      end
      set_lane(k, lane);
      tgt[k] <= ~idle;
      wait_cyc(5);
      chk(32'({wake_any, wake_req}), 32'h0, "disabled");
   endtask : t_mode

   ////////////////////////////////////////////////////////////////
   initial begin
      mclk        = 1'b0;
      rst_n       = 1'b0;
      wr          = 1'b0;
      rd          = 1'b0;
      addr        = 4'h0;
      wdata       = 32'h0000_0000;
      tgt         = 4'h0;
      ctrl        = 32'h2020_2020;
      n_errors    = 0;
      checks_done = 0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      wait_cyc(3);
      t_reset_word();
      t_ro_bits();
      t_b2b();
      for (int c = 0; c < 5; c++) begin
         t_mode(c % 4, 3'(c));
      end
      complete_run();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(100 * 4000);
      n_errors++;
      complete_run();
   end
endmodule : tb_swm_wake_ctrl

`default_nettype wire
